// >>> rtl/rss_top.sv
//----------------------------------------------------------------------------
// Purpose: Reset source sequencer, gathers reset causes and sequences
//          pin, core and register initialisation
// Assumes: hw_reset2_req, watchdog and oscillator inputs are on ref_clk
// Notes:   Pin release is filtered before the core restarts
// Notes on behaviour
// - Five reset sources, each reinitialises defined state
// - Hardware reset from pin or internal detector
// - Pin low forces pins to reset immediately
// - Pin low reinitialises and restarts the oscillator
// - Pin release inits core, then fetches vector
// - Hardware reset leaves internal RAM untouched
// - Pin reset during RAM write marks RAM indeterminate
// - Hardware reset loads pull-up from boot pin
// - Other resets load pull-up from processor mode
// - Software request bit triggers full reset sequence
// - Non-hardware resets keep the processor mode field
// - Watchdog underflow resets when select bit set
//----------------------------------------------------------------------------
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rss_top
   import rss_pkg::*;
#(
   parameter int INIT_CYCLES = RSS_INIT_CYCLES,
   parameter int AW = RSS_ADDR_W
)
(
   input wire logic ref_clk, // System clock, 40 MHz
   input wire logic rst, // Power-on reset, async, active high
   input wire logic reset_pin_n, // External reset pin, active low
   input wire logic boot_mode_select_pin, // Boot mode strap pin
   input wire logic hw_reset2_req, // Internal detector reset, level
   input wire logic watchdog_underflow, // Watchdog underflow pulse
   input wire logic osc_stop_detect, // Main oscillator stop pulse
   input wire logic ram_write_active, // Internal RAM write under way
   input wire logic [AW-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [AW-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   output logic pins_reset_state, // Force all pins to reset state
   output logic osc_reinit, // Oscillator circuit reinitialise
   output logic core_reset, // Core and special registers held
   output logic vector_fetch, // One-cycle reset vector fetch start
   output logic [7:0] pull_up_control_second, // Pull-up register value
   output logic [1:0] processor_mode, // Processor mode field
   output logic ram_indeterminate // RAM contents not trusted
);

   //-------------------------------------------------------------------------
   // Pin synchronisation
   //-------------------------------------------------------------------------
   logic [1:0] pin_sync;
   logic pin_high, boot_high;

   // Reset value models the pin held low until proven released
   rss_sync #(.W(2), .RST_VAL(2'b00)) u_sync
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in({boot_mode_select_pin, reset_pin_n}),
      .sync_out(pin_sync)
   );
   assign pin_high = pin_sync[0];
   assign boot_high = pin_sync[1];

   //-------------------------------------------------------------------------
   // Register bus
   //-------------------------------------------------------------------------
   logic reg_wr, reg_wok, reg_rok;
   logic [AW-1:0] reg_waddr, reg_raddr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [3:0] reg_wstrb;

   rss_axil #(.AW(AW)) u_axil
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .reg_wr(reg_wr),
      .reg_waddr(reg_waddr),
      .reg_wdata(reg_wdata),
      .reg_wstrb(reg_wstrb),
      .reg_wok(reg_wok),
      .reg_raddr(reg_raddr),
      .reg_rdata(reg_rdata),
      .reg_rok(reg_rok)
   );

   //-------------------------------------------------------------------------
   // State
   //-------------------------------------------------------------------------
   rss_state_t state_r, state_nxt;
   logic [RSS_CNT_W-1:0] cnt_r, cnt_nxt;
   logic [1:0] mode_r, mode_nxt;
   logic wdt_sel_r, wdt_sel_nxt;
   logic osc_cont_r, osc_cont_nxt;
   logic [7:0] pur_r, pur_nxt;
   logic [3:0] cause_r, cause_nxt;
   logic ram_ind_r, ram_ind_nxt;

   logic hw_hold, wr_b0, wr_mode0, wr_mode1, wr_status;
   logic sw_evt, wdt_evt, osc_evt, soft_evt, hw_entry, core_busy;

   assign wr_b0 = reg_wr & reg_wstrb[0] & ~core_busy;
   assign wr_mode0 = wr_b0 && reg_waddr == RSS_MODE0_OFS;
   assign wr_mode1 = wr_b0 && reg_waddr == RSS_MODE1_OFS;
   assign wr_status = wr_b0 && reg_waddr == RSS_STATUS_OFS;

   assign hw_hold = ~pin_high | hw_reset2_req;
   assign sw_evt = wr_mode0 & reg_wdata[RSS_SW_REQ_BIT];
   assign wdt_evt = watchdog_underflow & wdt_sel_r;
   // Continue bit clear means a stop detection resets the device
   assign osc_evt = osc_stop_detect & ~osc_cont_r;
   assign soft_evt = sw_evt | wdt_evt | osc_evt;
   assign hw_entry = hw_hold && state_r != RSS_ST_HOLD;
   assign core_busy = state_r == RSS_ST_HOLD || state_r == RSS_ST_INIT;

   //-------------------------------------------------------------------------
   // Sequencer
   //-------------------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      if (hw_hold)
      begin
         state_nxt = RSS_ST_HOLD;
         cnt_nxt = '0;
      end
      else
      begin
         unique case (state_r)
            RSS_ST_RUN:
            begin
               if (soft_evt)
               begin
                  state_nxt = RSS_ST_INIT;
                  cnt_nxt = '0;
               end
            end
            RSS_ST_HOLD:
               state_nxt = RSS_ST_INIT;
            RSS_ST_INIT:
            begin
               if (cnt_r == RSS_CNT_W'(INIT_CYCLES - 1))
                  state_nxt = RSS_ST_VEC;
               else
                  cnt_nxt = cnt_r + 1'b1;
            end
            RSS_ST_VEC:
               state_nxt = RSS_ST_RUN;
         endcase
      end
   end

   //-------------------------------------------------------------------------
   // Mode, pull-up and cause registers
   //-------------------------------------------------------------------------
   always_comb
   begin
      mode_nxt = mode_r;
      wdt_sel_nxt = wdt_sel_r;
      osc_cont_nxt = osc_cont_r;
      pur_nxt = pur_r;
      cause_nxt = cause_r;
      if (wr_mode0)
         mode_nxt = reg_wdata[RSS_MODE_HIGH_BIT:RSS_MODE_LOW_BIT];
      if (wr_mode1)
      begin
         wdt_sel_nxt = reg_wdata[RSS_WDT_SEL_BIT];
         osc_cont_nxt = reg_wdata[RSS_OSC_CONT_BIT];
      end
      if (hw_hold)
      begin
         // Strap is sampled on every cycle of the hold, last one wins
         mode_nxt = RSS_MODE_SINGLE;
         wdt_sel_nxt = 1'b0;
         osc_cont_nxt = 1'b0;
         pur_nxt = boot_high ? RSS_PUR_EXPAND : RSS_PUR_SINGLE;
         if (hw_entry)
            cause_nxt = pin_high ? RSS_CAUSE_HW2 : RSS_CAUSE_HW1;
      end
      else if (state_r == RSS_ST_RUN && soft_evt)
      begin
         // Processor mode is deliberately left as it was
         mode_nxt = mode_r;
         wdt_sel_nxt = 1'b0;
         osc_cont_nxt = 1'b0;
         pur_nxt = (mode_r == RSS_MODE_SINGLE) ? RSS_PUR_SINGLE
                                               : RSS_PUR_EXPAND;
         if (sw_evt)
            cause_nxt = RSS_CAUSE_SW;
         else if (wdt_evt)
            cause_nxt = RSS_CAUSE_WDT;
         else
            cause_nxt = RSS_CAUSE_OSC;
      end
   end

   //-------------------------------------------------------------------------
   // RAM integrity flag
   //-------------------------------------------------------------------------
   // No RAM clear path exists here; only this flag reports damage
   always_comb
   begin
      ram_ind_nxt = ram_ind_r;
      if (wr_status && reg_wdata[RSS_RAM_IND_BIT])
         ram_ind_nxt = 1'b0;
      if (hw_entry && ~pin_high && ram_write_active)
         ram_ind_nxt = 1'b1;
   end

   //-------------------------------------------------------------------------
   // Registers
   //-------------------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= RSS_ST_HOLD;
         cnt_r <= '0;
         mode_r <= RSS_MODE_SINGLE;
         wdt_sel_r <= 1'b0;
         osc_cont_r <= 1'b0;
         pur_r <= RSS_PUR_SINGLE;
         cause_r <= RSS_CAUSE_HW1;
         ram_ind_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         mode_r <= mode_nxt;
         wdt_sel_r <= wdt_sel_nxt;
         osc_cont_r <= osc_cont_nxt;
         pur_r <= pur_nxt;
         cause_r <= cause_nxt;
         ram_ind_r <= ram_ind_nxt;
      end
   end

   //-------------------------------------------------------------------------
   // Read decode
   //-------------------------------------------------------------------------
   always_comb
   begin
      reg_rdata = 32'h0;
      reg_rok = 1'b1;
      unique case (reg_raddr)
         RSS_MODE0_OFS:
            reg_rdata[RSS_MODE_HIGH_BIT:RSS_MODE_LOW_BIT] = mode_r;
         RSS_MODE1_OFS:
         begin
            reg_rdata[RSS_WDT_SEL_BIT] = wdt_sel_r;
            reg_rdata[RSS_OSC_CONT_BIT] = osc_cont_r;
         end
         RSS_PULLUP_OFS:
            reg_rdata[7:0] = pur_r;
         RSS_STATUS_OFS:
         begin
            reg_rdata[RSS_CAUSE_LSB+3:RSS_CAUSE_LSB] = cause_r;
            reg_rdata[RSS_RAM_IND_BIT] = ram_ind_r;
            reg_rdata[RSS_STATE_LSB+1:RSS_STATE_LSB] = state_r;
         end
         default:
            reg_rok = 1'b0;
      endcase
   end

   always_comb
   begin
      unique case (reg_waddr)
         RSS_MODE0_OFS, RSS_MODE1_OFS, RSS_PULLUP_OFS, RSS_STATUS_OFS:
            reg_wok = 1'b1;
         default:
            reg_wok = 1'b0;
      endcase
   end

   //-------------------------------------------------------------------------
   // Outputs
   //-------------------------------------------------------------------------
   // Raw pin acts at once; the synchronised copy starts and ends the hold
   assign pins_reset_state = ~reset_pin_n | hw_reset2_req
                             | (state_r != RSS_ST_RUN);
   assign osc_reinit = ~reset_pin_n | (state_r == RSS_ST_HOLD);
   assign core_reset = core_busy;
   assign vector_fetch = state_r == RSS_ST_VEC;
   assign pull_up_control_second = pur_r;
   assign processor_mode = mode_r;
   assign ram_indeterminate = ram_ind_r;

endmodule
`default_nettype wire

// >>> rtl/rss_pkg.sv
//----------------------------------------------------------------------------
// Purpose: Shared constants for the reset source sequencer
// Assumes: 32-bit AXI4-Lite register access, 40 MHz ref_clk
// Notes:   Offsets are byte addresses of aligned words
//----------------------------------------------------------------------------
package rss_pkg;

   //-------------------------------------------------------------------------
   // Register map
   //-------------------------------------------------------------------------
   localparam int RSS_ADDR_W = 4;
   localparam logic [3:0] RSS_MODE0_OFS = 4'h0;
   localparam logic [3:0] RSS_MODE1_OFS = 4'h4;
   localparam logic [3:0] RSS_PULLUP_OFS = 4'h8;
   localparam logic [3:0] RSS_STATUS_OFS = 4'hC;

   //-------------------------------------------------------------------------
   // Field positions
   //-------------------------------------------------------------------------
   localparam int RSS_MODE_LOW_BIT = 0;
   localparam int RSS_MODE_HIGH_BIT = 1;
   localparam int RSS_SW_REQ_BIT = 3;
   localparam int RSS_WDT_SEL_BIT = 2;
   localparam int RSS_OSC_CONT_BIT = 7;
   localparam int RSS_CAUSE_LSB = 0;
   localparam int RSS_RAM_IND_BIT = 4;
   localparam int RSS_STATE_LSB = 8;

   //-------------------------------------------------------------------------
   // Reset values and loaded values
   //-------------------------------------------------------------------------
   localparam logic [1:0] RSS_MODE_SINGLE = 2'h0;
   localparam logic [7:0] RSS_PUR_SINGLE = 8'h00;
   localparam logic [7:0] RSS_PUR_EXPAND = 8'h02;
   localparam logic [3:0] RSS_CAUSE_HW1 = 4'h1;
   localparam logic [3:0] RSS_CAUSE_SW = 4'h2;
   localparam logic [3:0] RSS_CAUSE_WDT = 4'h4;
   localparam logic [3:0] RSS_CAUSE_OSC = 4'h8;
   localparam logic [3:0] RSS_CAUSE_HW2 = 4'h3;

   //-------------------------------------------------------------------------
   // Timing
   //-------------------------------------------------------------------------
   localparam int RSS_INIT_CYCLES = 28;
   localparam int RSS_CNT_W = 8;
   localparam logic [1:0] RSS_RESP_OKAY = 2'h0;
   localparam logic [1:0] RSS_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0]
   {
      RSS_ST_RUN = 2'b00,
      RSS_ST_HOLD = 2'b01,
      RSS_ST_INIT = 2'b10,
      RSS_ST_VEC = 2'b11
   } rss_state_t;

endpackage

// >>> rtl/rss_sync.sv
//----------------------------------------------------------------------------
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs are asynchronous to ref_clk
// Notes:   Output follows once stages two and three agree
//----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module rss_sync
#(
   parameter int W = 2,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input wire logic ref_clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic [W-1:0] async_in, // Raw pin levels
   output logic [W-1:0] sync_out // Filtered levels
);
   logic [W-1:0] s1_r, s2_r, s3_r, out_r;
   logic [W-1:0] out_nxt;

   always_comb
   begin
      out_nxt = out_r;
      for (int i = 0; i < W; i++)
      begin
         if (s2_r[i] == s3_r[i])
            out_nxt[i] = s3_r[i];
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         out_r <= RST_VAL;
      end
      else
      begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         out_r <= out_nxt;
      end
   end

   assign sync_out = out_r;
endmodule
`default_nettype wire

// >>> rtl/rss_axil.sv
//----------------------------------------------------------------------------
// Purpose: AXI4-Lite slave front end for the sequencer registers
// Assumes: One write and one read outstanding at most
// Notes:   Address and data are taken in either order
//----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module rss_axil
   import rss_pkg::*;
#(
   parameter int AW = RSS_ADDR_W
)
(
   input wire logic ref_clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic [AW-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [AW-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   output logic reg_wr, // Register write pulse
   output logic [AW-1:0] reg_waddr, // Register write address
   output logic [31:0] reg_wdata, // Register write data
   output logic [3:0] reg_wstrb, // Register write strobes
   input wire logic reg_wok, // Write address is mapped
   output logic [AW-1:0] reg_raddr, // Register read address
   input wire logic [31:0] reg_rdata, // Register read data
   input wire logic reg_rok // Read address is mapped
);
   logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
   logic aw_have_nxt, w_have_nxt, bvalid_nxt, rvalid_nxt;
   logic [AW-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;

   assign s_axi_awready = ~aw_have_r & ~bvalid_r;
   assign s_axi_wready = ~w_have_r & ~bvalid_r;
   assign s_axi_arready = ~rvalid_r;
   assign reg_wr = aw_have_r & w_have_r & ~bvalid_r;
   assign reg_waddr = awaddr_r;
   assign reg_wdata = wdata_r;
   assign reg_wstrb = wstrb_r;
   assign reg_raddr = s_axi_araddr;

   always_comb
   begin
      aw_have_nxt = aw_have_r;
      w_have_nxt = w_have_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (reg_wr)
      begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = reg_wok ? RSS_RESP_OKAY : RSS_RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
         bvalid_nxt = 1'b0;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_nxt = 1'b1;
         rdata_nxt = reg_rok ? reg_rdata : 32'h0;
         rresp_nxt = reg_rok ? RSS_RESP_OKAY : RSS_RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
         rvalid_nxt = 1'b0;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RSS_RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= RSS_RESP_OKAY;
      end
      else
      begin
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
endmodule
`default_nettype wire

// >>> tb/rss_pin_drv.sv
// Purpose: External reset circuit model driving the reset pin
// Assumes: The device clock runs throughout
// Notes:   A request holds the pin low for 20 clocks, never shorter
`timescale 1ns/1ps
`default_nettype none
module rss_pin_drv
(
   input wire logic ref_clk, // Device clock
   input wire logic go, // Request a pin reset
   output logic reset_pin_n // Reset pin, active low
);
   int n = 0;
   assign reset_pin_n = (n == 0);
   always @(posedge ref_clk)
      if (go)
         n <= 20;
      else if (n > 0)
         n <= n - 1;
endmodule
`default_nettype wire

// >>> tb/rss_top_chk.sv
// Purpose: Sequencing checks on the top-level outputs
// Assumes: INIT_CYCLES equals that of the bound instance
// Notes:   Soft entry is told apart by osc_reinit staying low
`timescale 1ns/1ps
`default_nettype none
module rss_top_chk
   import rss_pkg::*;
#(
   parameter int INIT_CYCLES = RSS_INIT_CYCLES
)
(
   input wire logic ref_clk, // Clock
   input wire logic rst, // Reset
   input wire logic reset_pin_n, // Pin
   input wire logic hw_reset2_req, // Detector
   input wire logic pins_reset_state, // Pins forced
   input wire logic osc_reinit, // Osc restart
   input wire logic core_reset, // Core held
   input wire logic vector_fetch, // Vector fetch
   input wire logic [7:0] pull_up_control_second, // Pull-up
   input wire logic [1:0] processor_mode, // Mode
   input wire logic ram_indeterminate // RAM flag
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence soft_go;
      $rose(core_reset) && !osc_reinit;
   endsequence
   sequence pin_back;
      $rose(reset_pin_n) && core_reset;
   endsequence
   pin_force_a: assert property (
      !reset_pin_n |-> pins_reset_state && osc_reinit) else $error("pin");
   hw_force_a: assert property (
      hw_reset2_req |-> pins_reset_state) else $error("hw2 pins");
   soft_len_a: assert property (
      soft_go |-> ##INIT_CYCLES vector_fetch) else $error("init len");
   soft_keep_a: assert property (
      soft_go |-> $stable(processor_mode) && pull_up_control_second ==
      (processor_mode == RSS_MODE_SINGLE ? RSS_PUR_SINGLE : RSS_PUR_EXPAND))
      else $error("soft load");
   hold_mode_a: assert property (
      osc_reinit && reset_pin_n |-> processor_mode == RSS_MODE_SINGLE)
      else $error("hold mode");
   vec_order_a: assert property (
      $fell(core_reset) |-> vector_fetch) else $error("vec order");
   vec_pulse_a: assert property (
      vector_fetch |=> !vector_fetch && !core_reset) else $error("vec len");
   sync_hold_a: assert property (
      pin_back |=> osc_reinit[*2]) else $error("sync");
   ram_flag_a: assert property (
      $rose(ram_indeterminate) |-> osc_reinit) else $error("ram flag");
endmodule
bind rss_top rss_top_chk #(.INIT_CYCLES(INIT_CYCLES)) chk_u (.ref_clk,
   .rst, .reset_pin_n, .hw_reset2_req, .pins_reset_state, .osc_reinit,
   .core_reset, .vector_fetch, .pull_up_control_second, .processor_mode,
   .ram_indeterminate);
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench for the reset source sequencer
// Assumes: INIT_CYCLES shortened to 2
// Notes:   Soft resets run with random modes from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rss_pkg::*;
   localparam int IC = 2;
   logic ref_clk = 1'h0, rst = 1'h1, go = 1'h0, hw_reset2_req = 1'h0;
   logic boot_mode_select_pin = 1'h0, ram_write_active = 1'h0;
   logic [1:0] ev = 2'h0, s_axi_bresp, s_axi_rresp, resp, md;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [3:0] s_axi_wstrb = 4'hF, cz [3];
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic pins_reset_state, osc_reinit, core_reset, vector_fetch;
   logic ram_indeterminate;
   logic [1:0] processor_mode;
   logic [7:0] pull_up_control_second;
   wire logic reset_pin_n;
   wire logic watchdog_underflow = ev[0];
   wire logic osc_stop_detect = ev[1];
   int errors = 0, num_checks = 0, cyc = 0, k;
   integer seed = 32'hEA42;
   rss_pin_drv drv_u (.ref_clk(ref_clk), .go(go), .reset_pin_n(reset_pin_n));
   rss_top #(.INIT_CYCLES(IC)) dut_u (.*);
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors++;
         end_of_test();
      end
   end
   function automatic logic [7:0] pur_exp(input logic [1:0] m);
      return (m == RSS_MODE_SINGLE) ? RSS_PUR_SINGLE : RSS_PUR_EXPAND;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      @(posedge ref_clk);
      while (s_axi_bvalid !== 1'h1)
      begin
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         @(posedge ref_clk);
      end
      s_axi_bready <= 1'h0;
      resp = s_axi_bresp;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      @(posedge ref_clk);
      while (s_axi_rvalid !== 1'h1)
      begin
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         @(posedge ref_clk);
      end
      s_axi_rready <= 1'h0;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   task automatic pulse(input logic [1:0] e);
      @(posedge ref_clk);
      ev <= e;
      @(posedge ref_clk);
      ev <= 2'h0;
   endtask
   task automatic vec();
      int n;
      n = 0;
      while (vector_fetch !== 1'h1 && n < 300)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(32'(vector_fetch), 32'h1);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      cz = '{RSS_CAUSE_SW, RSS_CAUSE_WDT, RSS_CAUSE_OSC};
      repeat (6) @(posedge ref_clk);
      rst <= 1'h0;
      vec();
      chk(32'(pull_up_control_second), 32'h0);
      rd(4'h2);
      chk(32'(resp), 32'(RSS_RESP_SLVERR));
      $display("test 1 done");
      for (int i = 0; i < 6; i++)
      begin
         k = i % 3;
         md = 2'($random(seed));
         wr(RSS_MODE0_OFS, 32'(md));
         wr(RSS_MODE1_OFS, 32'h80);
         pulse(2'h3);
         repeat (1) @(posedge ref_clk);
         chk(32'(core_reset), 32'h0);
         wr(RSS_MODE1_OFS, (k == 1) ? 32'h4 : 32'h0);
         if (k == 0) wr(RSS_MODE0_OFS, 32'(md) | 32'h8);
         else pulse((k == 1) ? 2'h1 : 2'h2);
         vec();
         chk(32'(pull_up_control_second), 32'(pur_exp(md)));
         chk(32'(processor_mode), 32'(md));
         rd(RSS_STATUS_OFS);
         chk(rdat & 32'hF, 32'(cz[k]));
         $display("test %0d done", i + 2);
      end
      boot_mode_select_pin <= 1'h1;
      ram_write_active <= 1'h1;
      go <= 1'h1;
      @(posedge ref_clk);
      go <= 1'h0;
      vec();
      ram_write_active <= 1'h0;
      chk(32'(pull_up_control_second), 32'(RSS_PUR_EXPAND));
      chk(32'(ram_indeterminate), 32'h1);
      rd(RSS_STATUS_OFS);
      chk(rdat & 32'hF, 32'(RSS_CAUSE_HW1));
      wr(RSS_STATUS_OFS, 32'h10);
      chk(32'(resp), 32'(RSS_RESP_OKAY));
      chk(32'(ram_indeterminate), 32'h0);
      $display("test 8 done");
      boot_mode_select_pin <= 1'h0;
      repeat (5) @(posedge ref_clk);
      hw_reset2_req <= 1'h1;
      repeat (8) @(posedge ref_clk);
      hw_reset2_req <= 1'h0;
      vec();
      chk(32'(pull_up_control_second), 32'(RSS_PUR_SINGLE));
      rd(RSS_STATUS_OFS);
      chk(rdat & 32'hF, 32'(RSS_CAUSE_HW2));
      $display("test 9 done");
      end_of_test();
   end
endmodule
`default_nettype wire
